// ==== verilog/dbg_pkg.sv ====
// Constants, field layouts and carrier types of the debug scan and clock switch logic
// Notes on behaviour
// - Tag chains address: index bits 28:22, segment 5:0; only 27:22 and 1:0 used
// - Tag reading format: valid bit 28, dirty bit 27, stored tag bits 26:0
// - At UPDATE-DR the addressed tag entry loads into the serial register
// - Coprocessor chain: 39 bits, bit 38 direction, 37:32 address, 31:0 value
// - Coprocessor chain: no capture action; update reads if bit 38 low, else writes
// - Outside debug the core runs on the memory clock, debug clock held low
// - In debug the core runs on the TAP-driven debug clock; selected clock is output
// - Memory wait input is ignored while the core runs on the debug clock
// - Acknowledge rises in memory clock high phase; switch at next falling edge
// - Restart instruction then RUN-TEST/IDLE returns the core to the memory clock
// - Serial test: chain 0 with INTEST gives debug clock in idle; EXTEST gives none
// - Debug status bit 4 is high when debug came from the compressed state
// - In debug, core clocks are separated by 67 scan clocks
// - Bit 33 low runs at debug speed; a following no-op with bit 33 high runs fast
// - Restart with speed flag runs at memory clock, then returns to debug, ack high
// - Debug status bit 3 goes high when a system-speed instruction has completed
// - After a system-speed access the speed bit captures high
// - System-speed accesses use caches normally; disabled caches stay untouched
// - Debug chain is 67 bits: 32 data, 32 instruction, three control bits
// - First speed-bit capture after entry: low for breakpoint, high for watchpoint
package dbg_pkg;

	// ----------------------------------------
	// Scan chain numbers and TAP instructions
	// ----------------------------------------
	localparam logic [4:0] CHAIN_CORE = 5'h00;
	localparam logic [4:0] CHAIN_DEBUG = 5'h01;
	localparam logic [4:0] CHAIN_ITAG = 5'h04;
	localparam logic [4:0] CHAIN_DTAG = 5'h05;
	localparam logic [4:0] CHAIN_COPROC = 5'h0F;
	localparam logic [3:0] INSTR_EXTEST = 4'h0;
	localparam logic [3:0] INSTR_RESTART = 4'h4;
	localparam logic [3:0] INSTR_INTEST = 4'hC;

	// ----------------------------------------
	// Chain lengths as top bit index, debug scan clock count and register width
	// ----------------------------------------
	localparam logic [6:0] TOP_DEBUG = 7'h42;
	localparam logic [6:0] TOP_TAG = 7'h1C;
	localparam logic [6:0] TOP_COPROC = 7'h26;
	localparam logic [6:0] TOP_SELECT = 7'h04;
	localparam logic [6:0] DBG_SCAN_CLOCKS = 7'h43;
	localparam int SR_W = 67;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int TAG_IDX_LO = 22;
	localparam int TAG_IDX_HI = 27;
	localparam int TAG_SEG_HI = 1;
	localparam int CP_DIR_BIT = 38;
	localparam int CP_ADR_LO = 32;
	localparam int CP_ADR_HI = 37;
	localparam int DBG_DDEN_BIT = 32;
	localparam int DBG_SPEED_BIT = 33;
	localparam int DBG_WB_BIT = 34;
	localparam int DBG_INSTR_LO = 35;
	localparam int STAT_SYSTEM_ACCESS_COMPLETE_BIT = 3;
	localparam int STAT_COMPRESSED_BIT = 4;
	localparam logic [4:0] STATUS_RESET = 5'h00;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic tck;
		logic tdi;
		logic capture;
		logic shift;
		logic update;
		logic idle;
		logic [3:0] instr;
		logic [4:0] chain;
		logic mem_clk;
		logic mem_wait_n;
		logic test_mode;
	} pins_t;

	typedef struct packed {
		logic valid;
		logic dirty;
		logic [26:0] tag;
	} tag_entry_t;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_DEBUG,
		ST_SYS_RUN,
		ST_SYS_BACK
	} mode_t;

endpackage : dbg_pkg

// ==== verilog/sync2.sv ====
// Two-stage synchroniser for a group of asynchronous inputs
module sync2 #(
	parameter int W = 18
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	always_comb begin
		st_nxt.s1 = async_i;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_o = st_r.s2;

endmodule : sync2

// ==== verilog/core_clk_switch.sv ====
// Glitch-free selection of the core clock between memory and debug clocks
module core_clk_switch (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Sources and request
	input wire logic mem_clk_i,
	input wire logic dbg_clk_i,
	input wire logic want_debug_i,
	// Result
	output logic core_clk_o,
	output logic on_debug_o
);

	typedef struct packed {
		logic sel;
		logic clk;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Change over only with core clock and incoming source both low
		if (st_r.sel != want_debug_i && !st_r.clk && !(want_debug_i ? dbg_clk_i : mem_clk_i)) begin
			st_nxt.sel = want_debug_i;
		end
		st_nxt.clk = st_nxt.sel ? dbg_clk_i : mem_clk_i;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign core_clk_o = st_r.clk;
	assign on_debug_o = st_r.sel;

endmodule : core_clk_switch

// ==== verilog/debug_scan_access_clock_switch.sv ====
// Debug scan access, clock switching and system-speed access control
module debug_scan_access_clock_switch (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// TAP side, asynchronous
	input wire logic tck_i,
	input wire logic tdi_i,
	input wire logic tap_capture_i,
	input wire logic tap_shift_i,
	input wire logic tap_update_i,
	input wire logic tap_idle_i,
	input wire logic [3:0] tap_instr_i,
	input wire logic [4:0] tap_chain_i,
	output logic tdo_o,
	// Memory side pins, asynchronous
	input wire logic memory_clock_i,
	input wire logic memory_wait_n_i,
	input wire logic test_mode_i,
	// Core side
	input wire logic debug_req_i,
	input wire logic entry_watchpoint_i,
	input wire logic watch_and_break_flag_i,
	input wire logic entry_compressed_i,
	input wire logic [31:0] core_data_i,
	input wire logic sys_done_i,
	input wire logic cache_en_i,
	output logic selected_clock_out_o,
	output logic debug_core_clock_o,
	output logic core_wait_n_o,
	output logic debug_acknowledge_o,
	output logic system_speed_access_o,
	output logic [31:0] scan_instr_o,
	output logic core_cache_en_o,
	output logic [4:0] debug_status_o,
	// Tag arrays
	output logic tag_rd_o,
	output logic tag_dcache_o,
	output logic [5:0] tag_index_o,
	output logic [1:0] tag_segment_o,
	input wire logic [28:0] tag_rdata_i,
	// Control coprocessor registers
	output logic cp_rd_o,
	output logic cp_wr_o,
	output logic [5:0] cp_addr_o,
	output logic [31:0] cp_wdata_o,
	input wire logic [31:0] cp_rdata_i
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		dbg_pkg::mode_t mode;
		logic [dbg_pkg::SR_W-1:0] sr;
		logic tdo;
		logic tck_d;
		logic cap_d;
		logic upd_d;
		logic idle_d;
		logic debug_core_clock;
		logic ack;
		logic first_cap;
		logic entry_flag;
		logic wb_flag;
		logic compressed;
		logic sys_comp;
		logic speed_scan;
		logic sys_pending;
		logic sys_access;
		logic [6:0] shift_cnt;
		logic wait_n;
		logic cache_en;
		logic [31:0] instr;
		logic tag_rd;
		logic tag_dc;
		logic [5:0] tag_idx;
		logic [1:0] tag_seg;
		logic tag_ld;
		logic cp_rd;
		logic cp_wr;
		logic cp_ld;
		logic [5:0] cp_addr;
		logic [31:0] cp_wdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	dbg_pkg::pins_t pins_async;
	dbg_pkg::pins_t pins;
	logic core_clk;
	logic on_debug;
	logic tck_rise;
	logic cap_ev;
	logic upd_ev;
	logic idle_ev;
	logic intest;
	logic [6:0] top_bit;
	dbg_pkg::tag_entry_t tag_entry;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	assign pins_async = '{tck: tck_i, tdi: tdi_i, capture: tap_capture_i, shift: tap_shift_i,
		update: tap_update_i, idle: tap_idle_i, instr: tap_instr_i, chain: tap_chain_i,
		mem_clk: memory_clock_i, mem_wait_n: memory_wait_n_i, test_mode: test_mode_i};

	sync2 #(
		.W($bits(dbg_pkg::pins_t))
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.async_i(pins_async),
		.sync_o(pins)
	);

	// ----------------------------------------
	// Core clock selection
	// ----------------------------------------
	core_clk_switch u_clk (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.mem_clk_i(pins.mem_clk),
		.dbg_clk_i(st_r.debug_core_clock),
		.want_debug_i((st_r.mode == dbg_pkg::ST_DEBUG) || pins.test_mode),
		.core_clk_o(core_clk),
		.on_debug_o(on_debug)
	);

	// ----------------------------------------
	// Events and decode
	// ----------------------------------------
	assign tck_rise = pins.tck && !st_r.tck_d;
	assign cap_ev = pins.capture && !st_r.cap_d;
	assign upd_ev = pins.update && !st_r.upd_d;
	assign idle_ev = pins.idle && !st_r.idle_d;
	assign intest = (pins.instr == dbg_pkg::INSTR_INTEST);
	assign tag_entry = dbg_pkg::tag_entry_t'(tag_rdata_i);

	always_comb begin
		case (pins.chain)
			dbg_pkg::CHAIN_DEBUG: top_bit = dbg_pkg::TOP_DEBUG;
			dbg_pkg::CHAIN_ITAG, dbg_pkg::CHAIN_DTAG: top_bit = dbg_pkg::TOP_TAG;
			dbg_pkg::CHAIN_COPROC: top_bit = dbg_pkg::TOP_COPROC;
			default: top_bit = dbg_pkg::TOP_SELECT;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.tck_d = pins.tck;
		st_nxt.cap_d = pins.capture;
		st_nxt.upd_d = pins.update;
		st_nxt.idle_d = pins.idle;
		st_nxt.tag_rd = 1'b0;
		st_nxt.cp_rd = 1'b0;
		st_nxt.cp_wr = 1'b0;
		st_nxt.tag_ld = 1'b0;
		st_nxt.cp_ld = 1'b0;
		st_nxt.tdo = st_r.sr[0];
		st_nxt.wait_n = on_debug ? 1'b1 : pins.mem_wait_n;
		st_nxt.cache_en = cache_en_i;

		// Serial shift, least significant bit first
		if (pins.shift && tck_rise) begin
			st_nxt.sr = {1'b0, st_r.sr[dbg_pkg::SR_W-1:1]};
			st_nxt.sr[top_bit] = pins.tdi;
			if (st_r.shift_cnt != dbg_pkg::DBG_SCAN_CLOCKS) begin
				st_nxt.shift_cnt = st_r.shift_cnt + 7'h01;
			end
		end

		// Capture; tag and coprocessor chains keep their contents
		if (cap_ev && intest && pins.chain == dbg_pkg::CHAIN_DEBUG) begin
			st_nxt.sr[31:0] = core_data_i;
			st_nxt.sr[dbg_pkg::DBG_WB_BIT] = st_r.wb_flag;
			st_nxt.sr[dbg_pkg::DBG_SPEED_BIT] = st_r.first_cap ? st_r.entry_flag
				: st_r.speed_scan;
			st_nxt.first_cap = 1'b0;
		end

		// Update actions
		if (upd_ev && intest) begin
			case (pins.chain)
				dbg_pkg::CHAIN_ITAG, dbg_pkg::CHAIN_DTAG: begin
					st_nxt.tag_rd = 1'b1;
					st_nxt.tag_ld = 1'b1;
					st_nxt.tag_dc = (pins.chain == dbg_pkg::CHAIN_DTAG);
					st_nxt.tag_idx = st_r.sr[dbg_pkg::TAG_IDX_HI:dbg_pkg::TAG_IDX_LO];
					st_nxt.tag_seg = st_r.sr[dbg_pkg::TAG_SEG_HI:0];
				end
				dbg_pkg::CHAIN_COPROC: begin
					st_nxt.cp_addr = st_r.sr[dbg_pkg::CP_ADR_HI:dbg_pkg::CP_ADR_LO];
					st_nxt.cp_wdata = st_r.sr[31:0];
					st_nxt.cp_wr = st_r.sr[dbg_pkg::CP_DIR_BIT];
					st_nxt.cp_rd = !st_r.sr[dbg_pkg::CP_DIR_BIT];
					st_nxt.cp_ld = !st_r.sr[dbg_pkg::CP_DIR_BIT];
				end
				dbg_pkg::CHAIN_DEBUG: begin
					st_nxt.instr = st_r.sr[dbg_pkg::SR_W-1:dbg_pkg::DBG_INSTR_LO];
					st_nxt.speed_scan = st_r.sr[dbg_pkg::DBG_SPEED_BIT];
				end
				default: begin
				end
			endcase
		end

		// Read data returns one cycle after the strobe
		if (st_r.tag_ld) begin
			st_nxt.sr = '0;
			st_nxt.sr[dbg_pkg::TOP_TAG:0] = {tag_entry.valid, tag_entry.dirty,
				tag_entry.tag};
		end
		if (st_r.cp_ld) begin
			st_nxt.sr[31:0] = cp_rdata_i;
		end

		// Debug clock follows the test clock high phase in RUN-TEST/IDLE
		st_nxt.debug_core_clock = 1'b0;
		if (pins.test_mode) begin
			st_nxt.debug_core_clock = pins.idle && pins.tck && intest
				&& pins.chain == dbg_pkg::CHAIN_CORE;
		end else if (st_r.mode == dbg_pkg::ST_DEBUG && on_debug) begin
			st_nxt.debug_core_clock = pins.idle && pins.tck && intest && pins.chain == dbg_pkg::CHAIN_DEBUG
				&& (st_r.debug_core_clock || st_r.shift_cnt == dbg_pkg::DBG_SCAN_CLOCKS);
		end
		if (st_nxt.debug_core_clock && !st_r.debug_core_clock && !pins.test_mode) begin
			st_nxt.shift_cnt = 7'h00;
			st_nxt.sys_pending = st_r.speed_scan;
		end

		// Debug and system-speed sequencing
		case (st_r.mode)
			dbg_pkg::ST_RUN: begin
				if (debug_req_i && pins.mem_clk && !pins.test_mode) begin
					st_nxt.ack = 1'b1;
					st_nxt.mode = dbg_pkg::ST_DEBUG;
					st_nxt.entry_flag = entry_watchpoint_i;
					st_nxt.wb_flag = watch_and_break_flag_i;
					st_nxt.compressed = entry_compressed_i;
					st_nxt.first_cap = 1'b1;
					st_nxt.shift_cnt = 7'h00;
				end
			end
			dbg_pkg::ST_DEBUG: begin
				if (idle_ev && pins.instr == dbg_pkg::INSTR_RESTART && on_debug) begin
					if (st_r.sys_pending) begin
						st_nxt.mode = dbg_pkg::ST_SYS_RUN;
						st_nxt.sys_access = 1'b1;
						st_nxt.sys_comp = 1'b0;
					end else begin
						st_nxt.mode = dbg_pkg::ST_RUN;
						st_nxt.ack = 1'b0;
					end
				end
			end
			dbg_pkg::ST_SYS_RUN: begin
				if (sys_done_i && !on_debug) begin
					st_nxt.sys_comp = 1'b1;
					st_nxt.sys_access = 1'b0;
					st_nxt.sys_pending = 1'b0;
					st_nxt.entry_flag = 1'b1;
					st_nxt.first_cap = 1'b1;
					st_nxt.shift_cnt = 7'h00;
					st_nxt.mode = dbg_pkg::ST_SYS_BACK;
				end
			end
			dbg_pkg::ST_SYS_BACK: begin
				st_nxt.mode = dbg_pkg::ST_DEBUG;
			end
			default: begin
				st_nxt.mode = dbg_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
			st_r.mode <= dbg_pkg::ST_RUN;
			st_r.wait_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign tdo_o = st_r.tdo;
	assign selected_clock_out_o = core_clk;
	assign debug_core_clock_o = st_r.debug_core_clock;
	assign core_wait_n_o = st_r.wait_n;
	assign debug_acknowledge_o = st_r.ack;
	assign system_speed_access_o = st_r.sys_access;
	assign scan_instr_o = st_r.instr;
	assign core_cache_en_o = st_r.cache_en;
	assign debug_status_o = {st_r.compressed, st_r.sys_comp, 3'h0};
	assign tag_rd_o = st_r.tag_rd;
	assign tag_dcache_o = st_r.tag_dc;
	assign tag_index_o = st_r.tag_idx;
	assign tag_segment_o = st_r.tag_seg;
	assign cp_rd_o = st_r.cp_rd;
	assign cp_wr_o = st_r.cp_wr;
	assign cp_addr_o = st_r.cp_addr;
	assign cp_wdata_o = st_r.cp_wdata;

endmodule : debug_scan_access_clock_switch

// ==== dv/jtag_host_model.sv ====
// Debug host model driving the test access port levels and test clock
module jtag_host_model (
	// Clock
	input wire logic sys_clk_i,
	// Test access port, lvl_o is {capture, shift, update, idle}
	output logic tck_o,
	output logic tdi_o,
	output logic [3:0] lvl_o,
	output logic [3:0] instr_o,
	output logic [4:0] chain_o,
	input wire logic tdo_i
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		tck_o = 1'b0;
		tdi_o = 1'b0;
		lvl_o = 4'h0;
		instr_o = 4'h0;
		chain_o = 5'h00;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : hold

	// Chain and instruction set together, held while used
	task automatic pick(input logic [4:0] c, input logic [3:0] i);
		chain_o = c;
		instr_o = i;
		hold(4);
	endtask : pick

	// One level pulse; idle carries one test clock pulse
	task automatic step(input logic [3:0] s);
		lvl_o = s;
		hold(4);
		tck_o = s[0];
		hold(4);
		tck_o = 1'b0;
		lvl_o = 4'h0;
		hold(6);
	endtask : step

	// Shift LSB first; test clock still and data inverted outside frames
	task automatic shift(input int n, input logic [66:0] din, output logic [66:0] dout);
		dout = 67'h0;
		lvl_o = 4'h4;
		hold(4);
		for (int k = 0; k < n; k++) begin
			tdi_o = din[k];
			dout[k] = tdo_i;
			hold(4);
			tck_o = 1'b1;
			hold(4);
			tck_o = 1'b0;
		end
		lvl_o = 4'h0;
		tdi_o = ~tdi_o;
		hold(4);
	endtask : shift
endmodule : jtag_host_model

// ==== dv/debug_scan_access_clock_switch_sva.sv ====
// Checker of the debug scan access and clock switch block
module debug_scan_access_clock_switch_sva (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Watched ports
	input wire logic test_mode_i,
	input wire logic debug_req_i,
	input wire logic tag_rd_o,
	input wire logic [5:0] tag_index_o,
	input wire logic cp_rd_o,
	input wire logic cp_wr_o,
	input wire logic core_wait_n_o,
	input wire logic debug_core_clock_o,
	input wire logic debug_acknowledge_o,
	input wire logic system_speed_access_o,
	input wire logic [4:0] debug_status_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_tag_rd_pulse: assert property (tag_rd_o |=> !tag_rd_o)
		else $error("tag read pulse too long");
	a_tag_idx_hold: assert property (!tag_rd_o |-> $stable(tag_index_o))
		else $error("tag index moved without a read");
	a_cp_one_pulse: assert property ((cp_rd_o || cp_wr_o) |=> !(cp_rd_o || cp_wr_o))
		else $error("coprocessor strobe too long");
	a_cp_rd_wr_excl: assert property (!(cp_rd_o && cp_wr_o))
		else $error("coprocessor read and write together");
	a_wait_ignored: assert property (debug_core_clock_o |-> core_wait_n_o)
		else $error("wait passed while on debug clock");
	a_debug_core_clock_low_run: assert property ((!debug_acknowledge_o && !test_mode_i
		&& !$past(test_mode_i, 4)) |-> !debug_core_clock_o)
		else $error("debug clock high outside debug");
	a_ack_from_req: assert property ($rose(debug_acknowledge_o) |-> $past(debug_req_i))
		else $error("acknowledge without request");
	a_sys_keeps_ack: assert property (system_speed_access_o |-> debug_acknowledge_o)
		else $error("acknowledge low during system access");
	a_system_access_complete_cause: assert property ($rose(debug_status_o[3]) |-> $past(system_speed_access_o))
		else $error("complete flag without system access");
	a_sys_end_done: assert property ($fell(system_speed_access_o) |-> debug_status_o[3])
		else $error("system access ended without complete flag");

	c_tag_read: cover property (tag_rd_o);
	c_cp_write: cover property (cp_wr_o);
	c_sys_run: cover property ($rose(system_speed_access_o));
	c_dbg_clock: cover property ($rose(debug_core_clock_o));
endmodule : debug_scan_access_clock_switch_sva

bind debug_scan_access_clock_switch debug_scan_access_clock_switch_sva chk (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .test_mode_i(test_mode_i),
	.debug_req_i(debug_req_i), .tag_rd_o(tag_rd_o), .tag_index_o(tag_index_o),
	.cp_rd_o(cp_rd_o), .cp_wr_o(cp_wr_o), .core_wait_n_o(core_wait_n_o),
	.debug_core_clock_o(debug_core_clock_o), .debug_acknowledge_o(debug_acknowledge_o),
	.system_speed_access_o(system_speed_access_o), .debug_status_o(debug_status_o)
);

// ==== dv/tb_top.sv ====
// Self-checking bench of the debug scan access and clock switch block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic tck, tdi, tdo, mclk = 1'b0, mhold = 1'b0, wait_n = 1'b1, tmode = 1'b0;
	logic req = 1'b0, wpt = 1'b0, wab = 1'b0, cmp = 1'b0, done = 1'b0, cen = 1'b0;
	logic selclk, debug_core_clock, cwait, ack, sysacc, trd, tdc, cprd, cpwr, ccen;
	logic [3:0] lvl, instr;
	logic [4:0] chain, stat;
	logic [5:0] tidx, cpa;
	logic [1:0] tseg;
	logic [28:0] tag_rdata;
	logic [31:0] cdata = 32'h0, cp_rdata, sinstr, cpwd;
	logic [31:0] cp_mem [64];
	int miscompares = 0;
	int n_checks = 0;
	int debug_core_clock_n = 0;
	int trd_n = 0;
	int sel_n = 0;

	always #50 sys_clk_i = ~sys_clk_i;
	always begin
		repeat (6) @(negedge sys_clk_i);
		mclk = ~mclk & ~mhold;
	end
	always @(posedge debug_core_clock) debug_core_clock_n++;
	always @(posedge trd) trd_n++;
	always @(posedge selclk) sel_n++;
	always @(posedge sys_clk_i) if (cpwr) cp_mem[cpa] <= cpwd;
	assign cp_rdata = cp_mem[cpa];
	assign tag_rdata = tag_of(tdc, tidx, tseg);

	jtag_host_model host (.sys_clk_i(sys_clk_i), .tck_o(tck), .tdi_o(tdi), .lvl_o(lvl),
		.instr_o(instr), .chain_o(chain), .tdo_i(tdo));

	debug_scan_access_clock_switch dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .tck_i(tck),
		.tdi_i(tdi), .tap_capture_i(lvl[3]), .tap_shift_i(lvl[2]), .tap_update_i(lvl[1]),
		.tap_idle_i(lvl[0]), .tap_instr_i(instr), .tap_chain_i(chain), .tdo_o(tdo),
		.memory_clock_i(mclk), .memory_wait_n_i(wait_n), .test_mode_i(tmode),
		.debug_req_i(req), .entry_watchpoint_i(wpt), .watch_and_break_flag_i(wab),
		.entry_compressed_i(cmp), .core_data_i(cdata), .sys_done_i(done), .cache_en_i(cen),
		.selected_clock_out_o(selclk), .debug_core_clock_o(debug_core_clock), .core_wait_n_o(cwait),
		.debug_acknowledge_o(ack), .system_speed_access_o(sysacc), .scan_instr_o(sinstr),
		.core_cache_en_o(ccen), .debug_status_o(stat), .tag_rd_o(trd), .tag_dcache_o(tdc),
		.tag_index_o(tidx), .tag_segment_o(tseg), .tag_rdata_i(tag_rdata), .cp_rd_o(cprd),
		.cp_wr_o(cpwr), .cp_addr_o(cpa), .cp_wdata_o(cpwd), .cp_rdata_i(cp_rdata));

	function automatic logic [28:0] tag_of(input logic d, input logic [5:0] i,
		input logic [1:0] s);
		return {i[0], s[1], 3'h5, d, s, i, 15'h2C3A};
	endfunction : tag_of

	task automatic check(input logic [66:0] seen, input logic [66:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up;
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up

	// Tag read with reserved address bits set
	task automatic tag_test(input logic d);
		logic [66:0] dout;
		logic [5:0] i;
		logic [1:0] s;
		i = 6'($urandom);
		s = 2'($urandom);
		host.pick(d ? dbg_pkg::CHAIN_DTAG : dbg_pkg::CHAIN_ITAG, dbg_pkg::INSTR_INTEST);
		host.shift(29, {38'h0, 1'b1, i, 16'hFFFF, 4'hF, s}, dout);
		host.step(4'h2);
		check({tdc, tseg, tidx}, {d, s, i});
		host.shift(29, 67'h0, dout);
		check(dout[28:0], tag_of(d, i, s));
		$display("tag test done");
	endtask : tag_test

	// Coprocessor write, capture in between, then read back
	task automatic cp_test;
		logic [66:0] dout;
		logic [5:0] a;
		logic [31:0] v;
		a = 6'($urandom);
		v = $urandom;
		host.pick(dbg_pkg::CHAIN_COPROC, dbg_pkg::INSTR_INTEST);
		host.shift(39, {28'h0, 1'b1, a, v}, dout);
		host.step(4'h8);
		host.step(4'h2);
		check({cpa, cp_mem[a]}, {a, v});
		host.shift(39, {28'h0, 1'b0, a, ~v}, dout);
		host.step(4'h2);
		host.shift(39, 67'h0, dout);
		check(dout[38:0], {1'b0, a, v});
		$display("coprocessor test done");
	endtask : cp_test

	initial begin
		#5_000_000;
		miscompares++;
		wrap_up();
	end

	initial begin
		int k, n0, n1;
		logic [66:0] dout;
		logic [31:0] ins;
		void'($urandom(32'h1C48508D));
		repeat (6) @(negedge sys_clk_i);
		nrst_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		for (k = 0; k < 4; k++) begin
			wait_n = 1'($urandom);
			cen = 1'($urandom);
			done = 1'($urandom);
			tag_test(k[0]);
			cp_test();
			check(cwait, wait_n);
			check(ccen, cen);
		end
		n0 = trd_n;
		host.pick(dbg_pkg::CHAIN_ITAG, dbg_pkg::INSTR_EXTEST);
		host.step(4'h2);
		check(trd_n, n0);
		// Debug entry with random watchpoint, compressed-state and watch-and-break flags
		cdata = $urandom;
		wpt = 1'($urandom);
		cmp = 1'($urandom);
		wab = 1'($urandom);
		done = 1'b0;
		req = 1'b1;
		for (k = 0; k < 100 && ack !== 1'b1; k++) @(negedge sys_clk_i);
		req = 1'($urandom);
		check(stat[4], cmp);
		wait_n = 1'b0;
		repeat (30) @(negedge sys_clk_i);
		check(cwait, 1'b1);
		ins = $urandom;
		host.pick(dbg_pkg::CHAIN_DEBUG, dbg_pkg::INSTR_INTEST);
		host.step(4'h8);
		host.shift(67, {ins, 1'b0, 1'b1, 1'b0, 32'h0}, dout);
		check({dout[34:33], dout[31:0]}, {wab, wpt, cdata});
		host.step(4'h2);
		check(sinstr, ins);
		n0 = debug_core_clock_n;
		n1 = sel_n;
		host.step(4'h1);
		check(debug_core_clock_n, n0 + 1);
		check(sel_n, n1 + 1);
		host.step(4'h1);
		check(debug_core_clock_n, n0 + 1);
		host.pick(dbg_pkg::CHAIN_DEBUG, dbg_pkg::INSTR_RESTART);
		host.step(4'h1);
		check({sysacc, ack}, 2'b11);
		done = 1'b1;
		for (k = 0; k < 100 && stat[3] !== 1'b1; k++) @(negedge sys_clk_i);
		done = 1'b0;
		check(stat[3], 1'b1);
		repeat (30) @(negedge sys_clk_i);
		check({sysacc, ack}, 2'b01);
		host.pick(dbg_pkg::CHAIN_DEBUG, dbg_pkg::INSTR_INTEST);
		host.shift(67, {ins, 35'h0}, dout);
		host.step(4'h2);
		host.step(4'h8);
		host.shift(67, {ins, 35'h0}, dout);
		check(dout[33], 1'b1);
		host.step(4'h2);
		host.step(4'h1);
		req = 1'b0;
		host.pick(dbg_pkg::CHAIN_DEBUG, dbg_pkg::INSTR_RESTART);
		host.step(4'h1);
		repeat (30) @(negedge sys_clk_i);
		check(ack, 1'b0);
		$display("debug test done");
		// Serial test with the memory clock held low
		wait_n = 1'b1;
		mhold = 1'b1;
		tmode = 1'b1;
		host.pick(dbg_pkg::CHAIN_CORE, dbg_pkg::INSTR_INTEST);
		n0 = debug_core_clock_n;
		host.step(4'h1);
		host.pick(dbg_pkg::CHAIN_CORE, dbg_pkg::INSTR_EXTEST);
		host.step(4'h1);
		check(debug_core_clock_n, n0 + 1);
		host.pick(dbg_pkg::CHAIN_CORE, dbg_pkg::INSTR_RESTART);
		$display("serial test done");
		wrap_up();
	end
endmodule : tb_top
